//--- hdl/lmfc_align.sv
// LMFC offset, SYSREF capture and SYNC_N/ILAS alignment for a transmit and a receive link.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Counter resets exactly two link clocks after SYSREF is sampled high.
// - A SYSREF reset loads the programmed offset into the counter, not zero.
// - Receive offset 5 in an eight-count multiframe moves boundaries three clocks later.
// - Transmit offset 4 delays boundary four clocks; offset 5 delays it three.
// - Receive SYNC_N is released only on a receive LMFC boundary.
// - ILAS starts at the first transmit boundary after SYNC_N release is seen.
// - A later boundary thanks to offset lets ILAS start one boundary sooner.
// - Receive elastic buffer is released at a fixed LMFC count set by the release offset, repeatably.
// - Buffer depth is F x K/4; skew beyond it raises lane deskew error.
// - First detected SYSREF clears the single-detect bit in control register 0x54.
// - With single-detect clear, SYSREF is ignored until a control write sets it again or that side's control reset.
// - Software writes single-detect to 1 after link reset to resample SYSREF.
// - SYNC_N driven low after link is up starts reinitialisation.
// - Scrambling applies only in the user data phase, never CGS or ILAS.
// - Counter runs 0 to F x K/4 - 1 and wraps; wrap marks a boundary.
// - Buffer-release offset zero releases at boundary; n releases n counts earlier.
// - Lane deskew error is bit 4 of the receive error status register.
module lmfc_align #(
  parameter int FK4     = lmfc_pkg::FK4_DEFAULT,
  parameter int ILAS_MF = lmfc_pkg::ILAS_MF_DEFAULT
) (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic                          transmit_csr_reset_low,
  input  wire logic                          receive_csr_reset_low,
  input  wire logic [lmfc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [lmfc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [lmfc_pkg::DATA_W-1:0]   reg_rdata,
  output logic                               irq,
  input  wire logic                          rx_sysref,
  input  wire logic                          tx_sysref,
  input  wire logic                          tx_sync_n,
  output logic                               rx_sync_n,
  input  wire logic                          rx_cgs_done,
  input  wire logic                          rx_resync_req,
  input  wire logic                          rx_first_arrival,
  input  wire logic                          rx_last_arrival,
  output logic                               rx_buffer_release,
  output logic                               rx_descramble_en,
  output logic                               tx_ilas_active,
  output logic                               tx_data_phase,
  output logic                               tx_scramble_en
);
  localparam int CW = lmfc_pkg::CNT_W;

  typedef struct packed {
    logic [1:0]                  rx_sref_sync;
    logic                        rx_sref_prev;
    logic [1:0]                  tx_sref_sync;
    logic                        tx_sref_prev;
    logic [1:0]                  tx_sync_sync;
    logic                        rx_pipe;
    logic                        tx_pipe;
    logic                        rx_sdet;
    logic                        tx_sdet;
    logic                        scr_en;
    logic [CW-1:0]               rx_off;
    logic [CW-1:0]               tx_off;
    logic [CW-1:0]               rbd_off;
    logic [7:0]                  err;
    logic [7:0]                  mask;
    logic                        sync_n;
    logic [CW:0]                 skew;
    logic                        rx_rel;
    logic                        tx_ilas;
    logic                        tx_data;
    logic [3:0]                  ilas_cnt;
    logic                        irq;
    logic                        rx_desc;
    logic                        tx_scr;
    logic [lmfc_pkg::DATA_W-1:0] rdata;
  } lmfc_state_s;

  localparam logic [CW-1:0] FK4_C     = CW'(FK4);
  localparam logic [CW:0]   DEPTH     = (CW+1)'(FK4);
  localparam logic [3:0]    ILAS_LAST = 4'(ILAS_MF - 1);

  lmfc_state_s st;
  lmfc_state_s next_st;

  lmfc_if rx_lc ();
  lmfc_if tx_lc ();

  lmfc_counter #(.FK4(FK4)) u_rx_cnt (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .lc      (rx_lc)
  );

  lmfc_counter #(.FK4(FK4)) u_tx_cnt (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .lc      (tx_lc)
  );

  // The counters only ever see the offset at the moment of the load.
  // Offsets at or above the multiframe length are not clamped, so software must keep them below it.
  assign rx_lc.load   = st.rx_pipe;
  assign rx_lc.offset = st.rx_off;
  assign tx_lc.load   = st.tx_pipe;
  assign tx_lc.offset = st.tx_off;

  logic          rx_sref_rise;
  logic          tx_sref_rise;
  logic          rx_take;
  logic          tx_take;
  logic          tx_sync_hi;
  logic [CW-1:0] rel_point;
  logic          rel_here;
  logic          wr_ctl;
  logic          wr_err;

  always_comb
  begin
    next_st = st;
    rx_sref_rise = st.rx_sref_sync[1] & ~st.rx_sref_prev;
    tx_sref_rise = st.tx_sref_sync[1] & ~st.tx_sref_prev;
    rx_take      = rx_sref_rise & st.rx_sdet;
    tx_take      = tx_sref_rise & st.tx_sdet;
    tx_sync_hi   = st.tx_sync_sync[1];
    rel_point    = (st.rbd_off == '0) ? '0 : FK4_C - st.rbd_off;
    rel_here     = (rx_lc.count == rel_point);
    wr_ctl       = reg_wr & (reg_addr == lmfc_pkg::ADDR_CONTROL);
    wr_err       = reg_wr & (reg_addr == lmfc_pkg::ADDR_ERR_STATUS);

    // The SYSREF and transmit SYNC_N pins pass two flops before anything looks at them.
    next_st.rx_sref_sync = {st.rx_sref_sync[0], rx_sysref};
    next_st.rx_sref_prev = st.rx_sref_sync[1];
    next_st.tx_sref_sync = {st.tx_sref_sync[0], tx_sysref};
    next_st.tx_sref_prev = st.tx_sref_sync[1];
    next_st.tx_sync_sync = {st.tx_sync_sync[0], tx_sync_n};

    // One pipeline stage plus the counter's load edge gives the fixed two clocks.
    next_st.rx_pipe = rx_take;
    next_st.tx_pipe = tx_take;

    // Register writes.
    if (wr_ctl)
    begin
      next_st.rx_sdet = reg_wdata[lmfc_pkg::CTL_RX_SDET];
      next_st.tx_sdet = reg_wdata[lmfc_pkg::CTL_TX_SDET];
      next_st.scr_en  = reg_wdata[lmfc_pkg::CTL_SCR_EN];
      next_st.rx_off  = reg_wdata[lmfc_pkg::CTL_RX_OFF_LSB +: CW];
      next_st.tx_off  = reg_wdata[lmfc_pkg::CTL_TX_OFF_LSB +: CW];
      next_st.rbd_off = reg_wdata[lmfc_pkg::CTL_RBD_OFF_LSB +: CW];
    end
    if (reg_wr && reg_addr == lmfc_pkg::ADDR_IRQ_MASK)
      next_st.mask = reg_wdata[7:0] & lmfc_pkg::ERR_IMPL_MASK;
    if (wr_err)
      next_st.err = st.err & ~reg_wdata[7:0];

    // A detected pulse disarms further capture; a hardware clear loses to a
    // software write in the same cycle so a rearm is never swallowed.
    if (rx_take && !wr_ctl)
      next_st.rx_sdet = 1'b0;
    if (tx_take && !wr_ctl)
      next_st.tx_sdet = 1'b0;

    // Receive SYNC_N: asserted at once, released only on a boundary.
    if (!rx_cgs_done || rx_resync_req)
      next_st.sync_n = 1'b0;
    else if (rx_lc.boundary)
      next_st.sync_n = 1'b1;

    // Elastic buffer release and lane skew accounting.
    if (!st.sync_n)
    begin
      next_st.rx_rel = 1'b0;
      next_st.skew   = '0;
    end
    else
    begin
      if (rx_last_arrival && rel_here)
        next_st.rx_rel = 1'b1;
      if (rx_first_arrival && !st.rx_rel && st.skew <= DEPTH)
        next_st.skew = st.skew + 1'b1;
    end

    // Transmit: ILAS starts on the first boundary after SYNC_N release is seen,
    // so a later boundary shift lets it start one boundary sooner.
    if (!tx_sync_hi)
    begin
      next_st.tx_ilas  = 1'b0;
      next_st.tx_data  = 1'b0;
      next_st.ilas_cnt = '0;
    end
    else if (tx_lc.boundary)
    begin
      if (!st.tx_ilas && !st.tx_data)
        next_st.tx_ilas = 1'b1;
      else if (st.tx_ilas)
      begin
        if (st.ilas_cnt == ILAS_LAST)
        begin
          next_st.tx_ilas  = 1'b0;
          next_st.tx_data  = 1'b1;
          next_st.ilas_cnt = '0;
        end
        else
          next_st.ilas_cnt = st.ilas_cnt + 1'b1;
      end
    end

    // Scrambling only once the user data phase is reached.
    next_st.tx_scr  = st.scr_en & next_st.tx_data;
    next_st.rx_desc = st.scr_en & next_st.rx_rel;

    // Sticky events; a set wins over a software clear in the same cycle.
    if (rx_take)
      next_st.err[lmfc_pkg::ERR_RX_SYSREF] = 1'b1;
    if (tx_take)
      next_st.err[lmfc_pkg::ERR_TX_SYSREF] = 1'b1;
    if (st.sync_n && rx_first_arrival && !st.rx_rel && st.skew == DEPTH)
      next_st.err[lmfc_pkg::ERR_DESKEW] = 1'b1;
    next_st.irq = |(next_st.err & next_st.mask);

    // Read data stand in the cycle after the strobe only.
    next_st.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        lmfc_pkg::ADDR_CONTROL:
        begin
          next_st.rdata[lmfc_pkg::CTL_RX_SDET]              = st.rx_sdet;
          next_st.rdata[lmfc_pkg::CTL_TX_SDET]              = st.tx_sdet;
          next_st.rdata[lmfc_pkg::CTL_SCR_EN]               = st.scr_en;
          next_st.rdata[lmfc_pkg::CTL_RX_OFF_LSB +: CW]     = st.rx_off;
          next_st.rdata[lmfc_pkg::CTL_TX_OFF_LSB +: CW]     = st.tx_off;
          next_st.rdata[lmfc_pkg::CTL_RBD_OFF_LSB +: CW]    = st.rbd_off;
        end
        lmfc_pkg::ADDR_ERR_STATUS: next_st.rdata[7:0] = st.err;
        lmfc_pkg::ADDR_IRQ_MASK:   next_st.rdata[7:0] = st.mask;
        lmfc_pkg::ADDR_LINK_STAT:
          next_st.rdata[20:0] = {st.rx_rel, st.tx_data, st.tx_ilas, tx_sync_hi,
                                 st.sync_n, tx_lc.count, rx_lc.count};
        default:                   next_st.rdata = '0;
      endcase
    end

    // Control resets restore each side's registers; the link reset leaves them
    // alone so software can rearm single-detect without a control reset.
    if (!receive_csr_reset_low)
    begin
      next_st.rx_sdet = lmfc_pkg::SDET_RESET;
      next_st.rx_off  = lmfc_pkg::OFFSET_RESET;
      next_st.rbd_off = lmfc_pkg::OFFSET_RESET;
      next_st.scr_en  = 1'b0;
      next_st.mask    = lmfc_pkg::MASK_RESET;
      next_st.err[lmfc_pkg::ERR_RX_SYSREF] = 1'b0;
      next_st.err[lmfc_pkg::ERR_DESKEW]    = 1'b0;
    end
    if (!transmit_csr_reset_low)
    begin
      next_st.tx_sdet = lmfc_pkg::SDET_RESET;
      next_st.tx_off  = lmfc_pkg::OFFSET_RESET;
      next_st.err[lmfc_pkg::ERR_TX_SYSREF] = 1'b0;
    end
    if (!nrst)
    begin
      next_st.rx_sref_sync = '0;
      next_st.rx_sref_prev = 1'b0;
      next_st.tx_sref_sync = '0;
      next_st.tx_sref_prev = 1'b0;
      next_st.tx_sync_sync = '0;
      next_st.rx_pipe      = 1'b0;
      next_st.tx_pipe      = 1'b0;
      next_st.sync_n       = 1'b0;
      next_st.skew         = '0;
      next_st.rx_rel       = 1'b0;
      next_st.tx_ilas      = 1'b0;
      next_st.tx_data      = 1'b0;
      next_st.ilas_cnt     = '0;
      next_st.rx_desc      = 1'b0;
      next_st.tx_scr       = 1'b0;
      next_st.rdata        = '0;
      next_st.irq          = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
    st <= next_st;

  assign reg_rdata         = st.rdata;
  assign irq               = st.irq;
  assign rx_sync_n         = st.sync_n;
  assign rx_buffer_release = st.rx_rel;
  assign rx_descramble_en  = st.rx_desc;
  assign tx_ilas_active    = st.tx_ilas;
  assign tx_data_phase     = st.tx_data;
  assign tx_scramble_en    = st.tx_scr;
endmodule : lmfc_align
`default_nettype wire

//--- hdl/lmfc_pkg.sv
// Shared constants for the LMFC offset and SYSREF alignment block.
package lmfc_pkg;
  localparam int          CNT_W           = 8;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  // Multiframe length in link clocks, F x K / 4 with F = 1 and K = 32.
  localparam int          FK4_DEFAULT     = 8;
  localparam int          ILAS_MF_DEFAULT = 4;
  // SYSREF sample to LMFC counter reset, in link clocks.
  localparam int          SYSREF_TO_RESET = 2;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h54;
  localparam logic [7:0]  ADDR_ERR_STATUS = 8'h60;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h64;
  localparam logic [7:0]  ADDR_LINK_STAT  = 8'h68;
  // Control register field positions.
  localparam int          CTL_RX_SDET     = 0;
  localparam int          CTL_TX_SDET     = 1;
  localparam int          CTL_SCR_EN      = 2;
  localparam int          CTL_RX_OFF_LSB  = 8;
  localparam int          CTL_TX_OFF_LSB  = 16;
  localparam int          CTL_RBD_OFF_LSB = 24;
  // Error status bit positions.
  localparam int          ERR_RX_SYSREF   = 0;
  localparam int          ERR_TX_SYSREF   = 1;
  localparam int          ERR_DESKEW      = 4;
  localparam logic [7:0]  ERR_IMPL_MASK   = 8'h13;
  // Values after reset.
  localparam logic        SDET_RESET      = 1'b1;
  localparam logic [7:0]  OFFSET_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
endpackage : lmfc_pkg

//--- hdl/lmfc_if.sv
// Carrier between the alignment top and one LMFC counter.
`timescale 1ns/1ps
`default_nettype none
interface lmfc_if;
  logic                         load;
  logic [lmfc_pkg::CNT_W-1:0]   offset;
  logic [lmfc_pkg::CNT_W-1:0]   count;
  logic                         boundary;
  modport ctrl (output load, output offset, input count, input boundary);
  modport cnt  (input load, input offset, output count, output boundary);
endinterface : lmfc_if
`default_nettype wire

//--- hdl/lmfc_counter.sv
// Local multiframe counter with offset preload.
`timescale 1ns/1ps
`default_nettype none
module lmfc_counter #(
  parameter int FK4 = lmfc_pkg::FK4_DEFAULT
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  lmfc_if.cnt       lc
);
  typedef struct packed {
    logic [lmfc_pkg::CNT_W-1:0] count;
    logic                       boundary;
  } lmfc_cnt_s;

  localparam logic [lmfc_pkg::CNT_W-1:0] LAST = lmfc_pkg::CNT_W'(FK4 - 1);

  lmfc_cnt_s st;
  lmfc_cnt_s next_st;

  always_comb
  begin
    next_st = st;
    if (lc.load)
      next_st.count = lc.offset;
    else if (st.count == LAST)
      next_st.count = '0;
    else
      next_st.count = st.count + 1'b1;
    // The flag marks the cycle in which the count stands at zero.
    next_st.boundary = (next_st.count == '0);
    if (!nrst)
    begin
      next_st.count    = '0;
      next_st.boundary = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
    st <= next_st;

  assign lc.count    = st.count;
  assign lc.boundary = st.boundary;
endmodule : lmfc_counter
`default_nettype wire

//--- sim/lmfc_align_monitor.sv
// Concurrent checks on the pins of the LMFC alignment block.
`timescale 1ns/1ps
`default_nettype none
module lmfc_align_monitor #(
  parameter int FK4     = lmfc_pkg::FK4_DEFAULT,
  parameter int ILAS_MF = lmfc_pkg::ILAS_MF_DEFAULT
) (
  input wire logic                        sys_clk,
  input wire logic                        nrst,
  input wire logic                        reg_rd,
  input wire logic [lmfc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        rx_cgs_done,
  input wire logic                        rx_resync_req,
  input wire logic                        rx_last_arrival,
  input wire logic                        rx_sync_n,
  input wire logic                        rx_buffer_release,
  input wire logic                        rx_descramble_en,
  input wire logic                        tx_sync_n,
  input wire logic                        tx_ilas_active,
  input wire logic                        tx_data_phase,
  input wire logic                        tx_scramble_en
);
  localparam int ILAS_LEN = ILAS_MF * FK4;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_sync_needs_cgs: assert property (!rx_cgs_done |=> !rx_sync_n)
    else $error("rx sync released without code group sync");
  a_resync_drops_sync: assert property (rx_resync_req |=> !rx_sync_n)
    else $error("resync request did not pull rx sync low");
  a_sync_rise_cause: assert property ($rose(rx_sync_n) |-> $past(rx_cgs_done) && !$past(rx_resync_req))
    else $error("rx sync rose without its cause");
  a_release_cause: assert property ($rose(rx_buffer_release) |-> $past(rx_sync_n) && $past(rx_last_arrival))
    else $error("buffer released before link sync or last lane");
  a_release_drops: assert property (!rx_sync_n [*2] |-> !rx_buffer_release)
    else $error("buffer still released while sync is requested");
  a_descramble_user: assert property (rx_descramble_en |-> rx_buffer_release)
    else $error("descrambling outside user data");
  a_scramble_user: assert property (tx_scramble_en |-> tx_data_phase && !tx_ilas_active)
    else $error("scrambling outside user data");
  a_ilas_after_sync: assert property ($rose(tx_ilas_active) |-> $past(tx_sync_n, 3))
    else $error("lane alignment started without sync release");
  a_ilas_length: assert property ($rose(tx_ilas_active) |-> ##ILAS_LEN $rose(tx_data_phase))
    else $error("user data did not follow the alignment multiframes");
  a_data_after_ilas: assert property ($rose(tx_data_phase) |-> $past(tx_ilas_active))
    else $error("user data began without alignment sequence");
  a_sync_low_stops: assert property (!tx_sync_n [*4] |-> !tx_ilas_active && !tx_data_phase)
    else $error("transmit phases kept while sync is requested");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its slot");
endmodule : lmfc_align_monitor
bind lmfc_align lmfc_align_monitor #(.FK4(FK4), .ILAS_MF(ILAS_MF)) i_monitor (
  .sys_clk(sys_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_cgs_done(rx_cgs_done),
  .rx_resync_req(rx_resync_req), .rx_last_arrival(rx_last_arrival), .rx_sync_n(rx_sync_n),
  .rx_buffer_release(rx_buffer_release), .rx_descramble_en(rx_descramble_en), .tx_sync_n(tx_sync_n),
  .tx_ilas_active(tx_ilas_active), .tx_data_phase(tx_data_phase), .tx_scramble_en(tx_scramble_en));
`default_nettype wire

//--- sim/lmfc_conv_model.sv
// Behavioural converter receiver that answers the transmit link with SYNC_N.
`timescale 1ns/1ps
`default_nettype none
module lmfc_conv_model #(
  parameter int FK4 = lmfc_pkg::FK4_DEFAULT
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       tx_sysref,
  input  wire logic       dac_go,
  input  wire logic [7:0] dac_off,
  output logic            tx_sync_n
);
  logic [7:0] lmfc_cnt;
  logic       armed;
  // Its own multiframe phase is set by SYSREF, so a late phase makes the answer arrive late.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || !dac_go)
    begin
      armed     <= 1'b0;
      tx_sync_n <= 1'b0;
    end
    else if (armed && lmfc_cnt == 8'h00)
    begin
      tx_sync_n <= 1'b1;
    end
    if (tx_sysref)
    begin
      lmfc_cnt <= dac_off;
      armed    <= dac_go;
    end
    else
    begin
      lmfc_cnt <= (lmfc_cnt == 8'(FK4 - 1)) ? 8'h00 : lmfc_cnt + 8'h01;
    end
  end
endmodule : lmfc_conv_model
`default_nettype wire

//--- sim/test_lmfc_align.sv
// Self-checking bench for the LMFC alignment block.
`timescale 1ns/1ps
`default_nettype none
module test_lmfc_align;
  localparam int FK4     = lmfc_pkg::FK4_DEFAULT;
  localparam int ILAS_MF = lmfc_pkg::ILAS_MF_DEFAULT;
  logic        sys_clk = 1'b0, nrst = 1'b0, tx_rst_n = 1'b0, rx_rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00, dac_off = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, irq, rx_sysref = 1'b0, tx_sysref = 1'b0, tx_sync_n, rx_sync_n;
  logic        rx_cgs_done = 1'b0, rx_resync_req = 1'b0, rx_first_arrival = 1'b0, rx_last_arrival = 1'b0;
  logic        rx_buffer_release, rx_descramble_en, tx_ilas_active, tx_data_phase, tx_scramble_en, dac_go = 1'b0;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #20 sys_clk = ~sys_clk;
  lmfc_align #(.FK4(FK4), .ILAS_MF(ILAS_MF)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .transmit_csr_reset_low(tx_rst_n), .receive_csr_reset_low(rx_rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .rx_sysref(rx_sysref), .tx_sysref(tx_sysref), .tx_sync_n(tx_sync_n), .rx_sync_n(rx_sync_n),
    .rx_cgs_done(rx_cgs_done), .rx_resync_req(rx_resync_req), .rx_first_arrival(rx_first_arrival),
    .rx_last_arrival(rx_last_arrival), .rx_buffer_release(rx_buffer_release),
    .rx_descramble_en(rx_descramble_en), .tx_ilas_active(tx_ilas_active), .tx_data_phase(tx_data_phase),
    .tx_scramble_en(tx_scramble_en));
  lmfc_conv_model #(.FK4(FK4)) i_conv (.sys_clk(sys_clk), .nrst(nrst), .tx_sysref(tx_sysref),
    .dac_go(dac_go), .dac_off(dac_off), .tx_sync_n(tx_sync_n));
  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, want);
  endtask : rd
  // Edge counts start at the edge that samples the SYSREF pulse; cgs and the first lane arrive at count 3.
  task automatic rx_trial(input logic [31:0] ctl, input int want_sync, input int want_rel, input int last_at);
    int s_at;
    int r_at;
    s_at = 0;
    r_at = 0;
    {rx_cgs_done, rx_first_arrival, rx_last_arrival} <= 3'b000;
    wr(lmfc_pkg::ADDR_CONTROL, ctl);
    @(posedge sys_clk) rx_sysref <= 1'b1;
    @(posedge sys_clk) rx_sysref <= 1'b0;
    for (int i = 1; i <= 40; i++)
    begin
      @(posedge sys_clk);
      if (i == 3)
        {rx_cgs_done, rx_first_arrival} <= 2'b11;
      if (i == last_at)
        rx_last_arrival <= 1'b1;
      #1;
      if (rx_sync_n === 1'b1 && s_at == 0)
        s_at = i;
      if (rx_buffer_release === 1'b1 && r_at == 0)
        r_at = i;
    end
    chk(s_at, want_sync);
    chk(r_at, want_rel);
    chk(rx_descramble_en, ctl[2]);
    rd(lmfc_pkg::ADDR_CONTROL, ctl & 32'hffff_fffe);
  endtask : rx_trial
  task automatic tx_trial(input logic [7:0] off, input logic [7:0] doff, input int want);
    int il;
    int dp;
    il = 0;
    dp = 0;
    dac_go <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(lmfc_pkg::ADDR_CONTROL, {8'h00, off, 16'h0006});
    @(posedge sys_clk) {tx_sysref, dac_off, dac_go} <= {1'b1, doff, 1'b1};
    @(posedge sys_clk) tx_sysref <= 1'b0;
    for (int i = 1; i <= 60; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (tx_ilas_active === 1'b1 && il == 0)
        il = i;
      if (tx_data_phase === 1'b1 && dp == 0)
        dp = i;
    end
    chk(il, want);
    chk(dp - il, ILAS_MF * FK4);
    chk(tx_scramble_en, 1'b1);
    rd(lmfc_pkg::ADDR_CONTROL, {8'h00, off, 16'h0004});
  endtask : tx_trial
  task automatic rx_scenarios;
    // The last lane just misses the boundary, so the first lane waits past the buffer depth.
    rx_trial(32'h0000_0001, 4, 20, 12);
    rd(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0011);
    chk(irq, 1'b0);
    wr(lmfc_pkg::ADDR_IRQ_MASK, 32'h0000_0010);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b1);
    wr(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0010);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    rx_trial(32'h0500_0005, 4, 7, 4);
    rx_trial(32'h0500_0501, 7, 10, 4);
    rd(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0001);
    @(posedge sys_clk) rx_resync_req <= 1'b1;
    @(posedge sys_clk) rx_resync_req <= 1'b0;
    #1;
    chk(rx_sync_n, 1'b0);
    wr(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0001);
    wr(lmfc_pkg::ADDR_CONTROL, 32'h0000_0000);
    @(posedge sys_clk) rx_sysref <= 1'b1;
    @(posedge sys_clk) rx_sysref <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0000);
    // The offset write and the ignored pulse must leave the receive count on its old phase.
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, lmfc_pkg::ADDR_LINK_STAT};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1;
    chk(reg_rdata[7:0], 8'h07);
    @(posedge sys_clk) rx_rst_n <= 1'b0;
    @(posedge sys_clk) rx_rst_n <= 1'b1;
    rd(lmfc_pkg::ADDR_CONTROL, 32'h0000_0001);
    rd(lmfc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
  endtask : rx_scenarios
  task automatic tx_scenarios;
    int offs[5] = '{0, 4, 5, 0, 4};
    int doffs[5] = '{0, 0, 0, 7, 7};
    int wants[5] = '{4, 8, 7, 12, 8};
    for (int k = 0; k < 5; k++)
      tx_trial(8'(offs[k]), 8'(doffs[k]), wants[k]);
    rd(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0002);
    @(posedge sys_clk) tx_rst_n <= 1'b0;
    @(posedge sys_clk) tx_rst_n <= 1'b1;
    rd(lmfc_pkg::ADDR_CONTROL, 32'h0000_0006);
    rd(lmfc_pkg::ADDR_ERR_STATUS, 32'h0000_0000);
  endtask : tx_scenarios
  initial
  begin
    repeat (12) @(posedge sys_clk);
    {nrst, tx_rst_n, rx_rst_n} <= 3'b111;
    rd(lmfc_pkg::ADDR_CONTROL, 32'h0000_0003);
    wr(8'h70, 32'hffff_ffff);
    rd(8'h70, 32'h0000_0000);
    rx_scenarios();
    tx_scenarios();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule : test_lmfc_align
`default_nettype wire
